//--- hw/vrc_pkg.sv
// Package for the video input routing configuration block.
// Shared by the serial register bank and the routing decoder.
// Assumes a single clock domain; serial pins are synchronous samples.
package vrc_pkg;

	// ==================================================================
	// Serial slave addressing
	// ==================================================================
	localparam logic [5:0] VRC_SLV_ADDR_HI  = 6'h10;   // 7-bit address bits 6:1
	localparam logic [3:0] VRC_BYTE_BITS    = 4'h8;    // Bits per serial byte

	// ==================================================================
	// Register offsets (subaddresses)
	// ==================================================================
	localparam logic [7:0] VRC_OFS_ROUTE    = 8'h00;   // input_route_select
	localparam logic [7:0] VRC_OFS_PAGE     = 8'h0e;   // register_page_select
	localparam logic [7:0] VRC_OFS_ACE      = 8'h80;   // contrast_enhance_control
	localparam logic [7:0] VRC_OFS_DEINT    = 8'h81;   // deinterlace control

	// ==================================================================
	// Field positions and page codes
	// ==================================================================
	localparam int         VRC_PAGE_LSB     = 5;       // Page field bits 6:5
	localparam int         VRC_ACE_BIT      = 7;       // Contrast boost enable
	localparam int         VRC_DEINT_BIT    = 0;       // Deinterlacer enable
	localparam logic [1:0] VRC_PAGE_MAIN    = 2'h0;    // Primary user page
	localparam logic [1:0] VRC_PAGE_INTR    = 2'h1;    // Interrupt / slicer page
	localparam logic [1:0] VRC_PAGE_USR2    = 2'h2;    // Second user page

	// ==================================================================
	// Reset values
	// ==================================================================
	localparam logic [4:0] VRC_RST_ROUTE    = 5'h00;
	localparam logic [1:0] VRC_RST_PAGE     = 2'h0;
	localparam logic [7:0] VRC_RST_ACE      = 8'h00;
	localparam logic [7:0] VRC_RST_DEINT    = 8'h00;

	// ==================================================================
	// Routing selection codes
	// ==================================================================
	localparam logic [4:0] VRC_COMPOSITE_VIDEO_LAST8   = 5'h07;   // Composite, eight inputs
	localparam logic [4:0] VRC_COMPOSITE_VIDEO_LAST4   = 5'h03;   // Composite, four inputs
	localparam logic [4:0] VRC_YC_FIRST     = 5'h08;
	localparam logic [4:0] VRC_YC_LAST8     = 5'h0b;
	localparam logic [4:0] VRC_YC_LAST4     = 5'h09;
	localparam logic [4:0] VRC_COMP_LO      = 5'h0c;   // Component on 1,2,3
	localparam logic [4:0] VRC_COMP_HI      = 5'h0d;   // Component on 4,5,6
	localparam logic [7:0] VRC_PWR_COMP_LO  = 8'h07;
	localparam logic [7:0] VRC_PWR_COMP_HI  = 8'h38;

	// Decoding core processing mode
	typedef enum logic [2:0] {
		VRC_MODE_COMPOSITE   = 3'h1,
		VRC_MODE_LUMA_CHROMA = 3'h2,
		VRC_MODE_COMPONENT   = 3'h4
	} vrc_mode_t;

	// Decoded route; channel numbers are zero based
	typedef struct packed {
		logic [7:0] chan_power;   // One bit per analog channel, 1 = powered
		vrc_mode_t  mode;         // Decoding core mode
		logic [2:0] luma_ch;      // Luma or composite channel
		logic [2:0] chroma_ch;    // Chroma or blue difference channel
		logic [2:0] third_ch;     // Red difference channel
		logic       valid;        // Code is defined for this variant
	} vrc_route_t;

	// Serial slave states
	typedef enum logic [8:0] {
		VRC_ST_IDLE = 9'h001,
		VRC_ST_ADDR = 9'h002,
		VRC_ST_AACK = 9'h004,
		VRC_ST_SUB  = 9'h008,
		VRC_ST_SACK = 9'h010,
		VRC_ST_WR   = 9'h020,
		VRC_ST_WACK = 9'h040,
		VRC_ST_RD   = 9'h080,
		VRC_ST_RACK = 9'h100
	} vrc_state_t;

endpackage : vrc_pkg

//--- hw/vrc_route_decode.sv
// Routing decoder: turns the five-bit selection code into channel power,
// channel assignment and decoding core mode. Outputs are registered.
// Assumes the code comes from a register in the same clock domain.
`timescale 1ns/1ps
module vrc_route_decode (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	// Selection
	input  wire logic [4:0]        code_i,
	input  wire logic              eight_ch_i,
	// Decoded route
	output vrc_pkg::vrc_route_t    route_o
);
	import vrc_pkg::*;

	vrc_route_t route_ff;   // Registered route
	vrc_route_t nxt_route;  // Next route

	// ==================================================================
	// Code decode
	// ==================================================================
	// Reserved codes keep every channel off and composite mode
	always_comb begin
		nxt_route = '0;
		nxt_route.mode = VRC_MODE_COMPOSITE;
		if (code_i <= VRC_COMPOSITE_VIDEO_LAST4 ||
		    (eight_ch_i && code_i <= VRC_COMPOSITE_VIDEO_LAST8)) begin
			// Single composite channel
			nxt_route.chan_power = 8'h01 << code_i[2:0];
			nxt_route.luma_ch    = code_i[2:0];
			nxt_route.valid      = 1'b1;
		end else if (code_i >= VRC_YC_FIRST && (code_i <= VRC_YC_LAST4 ||
		             (eight_ch_i && code_i <= VRC_YC_LAST8))) begin
			// Luma on the odd channel, chroma on the next
			nxt_route.chan_power = 8'h03 << {code_i[1:0], 1'b0};
			nxt_route.mode       = VRC_MODE_LUMA_CHROMA;
			nxt_route.luma_ch    = {code_i[1:0], 1'b0};
			nxt_route.chroma_ch  = {code_i[1:0], 1'b1};
			nxt_route.valid      = 1'b1;
		end else if (code_i == VRC_COMP_LO) begin
			// Component on channels 1, 2, 3
			nxt_route.chan_power = VRC_PWR_COMP_LO;
			nxt_route.mode       = VRC_MODE_COMPONENT;
			nxt_route.luma_ch    = 3'h0;
			nxt_route.chroma_ch  = 3'h1;
			nxt_route.third_ch   = 3'h2;
			nxt_route.valid      = 1'b1;
		end else if (code_i == VRC_COMP_HI && eight_ch_i) begin
			// Component on channels 4, 5, 6
			nxt_route.chan_power = VRC_PWR_COMP_HI;
			nxt_route.mode       = VRC_MODE_COMPONENT;
			nxt_route.luma_ch    = 3'h3;
			nxt_route.chroma_ch  = 3'h4;
			nxt_route.third_ch   = 3'h5;
			nxt_route.valid      = 1'b1;
		end
	end

	// Route register
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			route_ff <= '{chan_power: 8'h00, mode: VRC_MODE_COMPOSITE,
			              luma_ch: 3'h0, chroma_ch: 3'h0, third_ch: 3'h0,
			              valid: 1'b0};
		end else begin
			route_ff <= nxt_route;
		end
	end

	assign route_o = route_ff;

endmodule : vrc_route_decode

//--- hw/vrc_route_config.sv
// Video input routing configuration: serial register bank and route
// decode. Holds the routing selection, page selection, contrast boost
// and deinterlacer enables.
// Assumes serial pins already synchronous to clk_i and an external
// open-drain pad resolving the data line from the enable.
`timescale 1ns/1ps
module vrc_route_config (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	// Serial register port
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe_o,
	// Straps
	input  wire logic              slave_address_select_pin_i,
	input  wire logic              eight_ch_variant_i,
	// Configuration outputs
	output vrc_pkg::vrc_route_t    route_o,
	output logic [1:0]             register_page_select_o,
	output logic                   adaptive_contrast_boost_o,
	output logic                   interlace_to_progressive_o
);
	import vrc_pkg::*;

	// ==================================================================
	// Declarations
	// ==================================================================
	logic       scl_s_ff;           // Sampled clock line
	logic       scl_p_ff;           // Previous clock sample
	logic       sda_s_ff;           // Sampled data line
	logic       sda_p_ff;           // Previous data sample
	vrc_state_t state_ff;           // Serial slave state
	vrc_state_t nxt_state;
	logic [3:0] cnt_ff;             // Bit counter
	logic [3:0] nxt_cnt;
	logic [7:0] shift_ff;           // Receive shifter
	logic [7:0] nxt_shift;
	logic [7:0] tx_ff;              // Transmit shifter
	logic [7:0] nxt_tx;
	logic [7:0] sub_ff;             // Current subaddress
	logic [7:0] nxt_sub;
	logic       rw_ff;              // 1 = read transfer
	logic       nxt_rw;
	logic       oe_ff;              // Pulls data line low
	logic       nxt_oe;
	logic [4:0] route_ff;           // input_route_select field
	logic [4:0] nxt_route;
	logic [1:0] page_ff;            // register_page_select field
	logic [1:0] nxt_page;
	logic [7:0] ace_ff;             // contrast_enhance_control
	logic [7:0] nxt_ace;
	logic [7:0] deint_ff;           // Deinterlace control
	logic [7:0] nxt_deint;
	logic       scl_rise;           // Clock line rising
	logic       scl_fall;           // Clock line falling
	logic       bus_start;          // Start condition
	logic       bus_stop;           // Stop condition
	logic       addr_hit;           // Received address is ours
	logic [7:0] sub_inc;            // Next subaddress

	// ==================================================================
	// Helper functions
	// ==================================================================
	// Subaddress exists on the given page
	function automatic logic reg_valid(input logic [1:0] page,
	                                   input logic [7:0] sub);
		logic ok;
		ok = (sub == VRC_OFS_PAGE);
		if (page == VRC_PAGE_MAIN && sub == VRC_OFS_ROUTE) begin
			ok = 1'b1;
		end
		if (page == VRC_PAGE_USR2 &&
		    (sub == VRC_OFS_ACE || sub == VRC_OFS_DEINT)) begin
			ok = 1'b1;
		end
		return ok;
	endfunction : reg_valid

	// Read value of a subaddress on the given page
	function automatic logic [7:0] read_reg(input logic [1:0] page,
	                                        input logic [7:0] sub,
	                                        input logic [4:0] route,
	                                        input logic [7:0] ace,
	                                        input logic [7:0] deint);
		logic [7:0] val;
		val = 8'h00;
		if (sub == VRC_OFS_PAGE) begin
			// Unused bits of the page register read zero
			val[VRC_PAGE_LSB +: 2] = page;
		end else if (page == VRC_PAGE_MAIN && sub == VRC_OFS_ROUTE) begin
			val[4:0] = route;
		end else if (page == VRC_PAGE_USR2 && sub == VRC_OFS_ACE) begin
			val = ace;
		end else if (page == VRC_PAGE_USR2 && sub == VRC_OFS_DEINT) begin
			val = deint;
		end
		return val;
	endfunction : read_reg

	// ==================================================================
	// Line sampling
	// ==================================================================
	// Current and previous samples of both lines
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_s_ff <= 1'b1;
			scl_p_ff <= 1'b1;
			sda_s_ff <= 1'b1;
			sda_p_ff <= 1'b1;
		end else begin
			scl_s_ff <= scl_i;
			scl_p_ff <= scl_s_ff;
			sda_s_ff <= sda_i;
			sda_p_ff <= sda_s_ff;
		end
	end

	// Edge and condition detection
	assign scl_rise  = scl_s_ff & ~scl_p_ff;
	assign scl_fall  = ~scl_s_ff & scl_p_ff;
	assign bus_start = scl_s_ff & scl_p_ff & sda_p_ff & ~sda_s_ff;
	assign bus_stop  = scl_s_ff & scl_p_ff & ~sda_p_ff & sda_s_ff;
	// One address for every page; the strap sets 7-bit address bit 0
	assign addr_hit  = (shift_ff[7:1] ==
	                    {VRC_SLV_ADDR_HI, slave_address_select_pin_i});
	assign sub_inc   = sub_ff + 8'h01;

	// ==================================================================
	// Serial slave and register bank, next state
	// ==================================================================
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_shift = shift_ff;
		nxt_tx    = tx_ff;
		nxt_sub   = sub_ff;
		nxt_rw    = rw_ff;
		nxt_oe    = oe_ff;
		nxt_route = route_ff;
		nxt_page  = page_ff;
		nxt_ace   = ace_ff;
		nxt_deint = deint_ff;
		// Shift in on every rising clock; count bits only while receiving or sending
		if (scl_rise) begin
			nxt_shift = {shift_ff[6:0], sda_s_ff};
			if (state_ff == VRC_ST_ADDR || state_ff == VRC_ST_SUB ||
			    state_ff == VRC_ST_WR || state_ff == VRC_ST_RD) begin
				nxt_cnt = cnt_ff + 4'h1;
			end
		end
		case (state_ff)
			VRC_ST_IDLE: begin
				// Wait for a start condition
				nxt_oe = 1'b0;
			end
			VRC_ST_ADDR: begin
				// Address byte; acknowledge only our address
				if (scl_fall && cnt_ff == VRC_BYTE_BITS) begin
					if (addr_hit) begin
						nxt_oe    = 1'b1;
						nxt_rw    = shift_ff[0];
						nxt_state = VRC_ST_AACK;
					end else begin
						nxt_state = VRC_ST_IDLE;
					end
				end
			end
			VRC_ST_AACK: begin
				// End of address acknowledge
				if (scl_fall) begin
					nxt_cnt = 4'h0;
					if (rw_ff) begin
						nxt_tx    = read_reg(page_ff, sub_ff, route_ff,
						                     ace_ff, deint_ff);
						nxt_oe    = ~nxt_tx[7];
						nxt_tx    = {nxt_tx[6:0], 1'b0};
						nxt_state = VRC_ST_RD;
					end else begin
						nxt_oe    = 1'b0;
						nxt_state = VRC_ST_SUB;
					end
				end
			end
			VRC_ST_SUB: begin
				// Subaddress byte; unknown subaddress is not acknowledged
				if (scl_fall && cnt_ff == VRC_BYTE_BITS) begin
					if (reg_valid(page_ff, shift_ff)) begin
						nxt_sub   = shift_ff;
						nxt_oe    = 1'b1;
						nxt_state = VRC_ST_SACK;
					end else begin
						nxt_state = VRC_ST_IDLE;
					end
				end
			end
			VRC_ST_SACK, VRC_ST_WACK: begin
				// Release after acknowledge; step subaddress after data
				if (scl_fall) begin
					nxt_oe    = 1'b0;
					nxt_cnt   = 4'h0;
					nxt_state = VRC_ST_WR;
					if (state_ff == VRC_ST_WACK) begin
						nxt_sub = sub_inc;
					end
				end
			end
			VRC_ST_WR: begin
				// Data byte: store it and acknowledge, or refuse it
				if (scl_fall && cnt_ff == VRC_BYTE_BITS) begin
					if (reg_valid(page_ff, sub_ff)) begin
						nxt_oe    = 1'b1;
						nxt_state = VRC_ST_WACK;
						if (sub_ff == VRC_OFS_PAGE) begin
							nxt_page = shift_ff[VRC_PAGE_LSB +: 2];
						end else if (page_ff == VRC_PAGE_MAIN) begin
							nxt_route = shift_ff[4:0];
						end else if (sub_ff == VRC_OFS_ACE) begin
							nxt_ace = shift_ff;
						end else begin
							nxt_deint = shift_ff;
						end
					end else begin
						nxt_state = VRC_ST_IDLE;
					end
				end
			end
			VRC_ST_RD: begin
				// Drive data on falling clock, release after bit eight
				if (scl_fall) begin
					if (cnt_ff == VRC_BYTE_BITS) begin
						nxt_oe    = 1'b0;
						nxt_state = VRC_ST_RACK;
					end else begin
						nxt_oe = ~tx_ff[7];
						nxt_tx = {tx_ff[6:0], 1'b0};
					end
				end
			end
			VRC_ST_RACK: begin
				// Master acknowledge: advance if the next subaddress exists on the page, or end on no acknowledge
				if (scl_rise) begin
					if (sda_s_ff) begin
						nxt_state = VRC_ST_IDLE;
					end else if (reg_valid(page_ff, sub_inc)) begin
						nxt_sub = sub_inc;
					end
				end else if (scl_fall) begin
					nxt_tx    = read_reg(page_ff, sub_ff, route_ff,
					                     ace_ff, deint_ff);
					nxt_oe    = ~nxt_tx[7];
					nxt_tx    = {nxt_tx[6:0], 1'b0};
					nxt_cnt   = 4'h0;
					nxt_state = VRC_ST_RD;
				end
			end
			default: begin
				nxt_oe    = 1'b0;
				nxt_state = VRC_ST_IDLE;
			end
		endcase
		// Start and stop override any state
		if (bus_start) begin
			nxt_oe    = 1'b0;
			nxt_cnt   = 4'h0;
			nxt_state = VRC_ST_ADDR;
		end else if (bus_stop) begin
			nxt_oe    = 1'b0;
			nxt_state = VRC_ST_IDLE;
		end
	end

	// ==================================================================
	// Serial slave and register bank, registers
	// ==================================================================
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_ff <= VRC_ST_IDLE;
			cnt_ff   <= 4'h0;
			shift_ff <= 8'h00;
			tx_ff    <= 8'h00;
			sub_ff   <= 8'h00;
			rw_ff    <= 1'b0;
			oe_ff    <= 1'b0;
			route_ff <= VRC_RST_ROUTE;
			page_ff  <= VRC_RST_PAGE;
			ace_ff   <= VRC_RST_ACE;
			deint_ff <= VRC_RST_DEINT;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			shift_ff <= nxt_shift;
			tx_ff    <= nxt_tx;
			sub_ff   <= nxt_sub;
			rw_ff    <= nxt_rw;
			oe_ff    <= nxt_oe;
			route_ff <= nxt_route;
			page_ff  <= nxt_page;
			ace_ff   <= nxt_ace;
			deint_ff <= nxt_deint;
		end
	end

	// ==================================================================
	// Route decode
	// ==================================================================
	// Route and core mode follow the selection field and the eight-channel variant strap
	vrc_route_decode u_decode (
		.clk_i      (clk_i),
		.rst_b_i    (rst_b_i),
		.code_i     (route_ff),
		.eight_ch_i (eight_ch_variant_i),
		.route_o    (route_o)
	);

	// ==================================================================
	// Outputs
	// ==================================================================
	// Open-drain: the line is only ever pulled low
	assign sda_o                      = 1'b0;
	assign sda_oe_o                   = oe_ff;
	assign register_page_select_o     = page_ff;
	assign adaptive_contrast_boost_o  = ace_ff[VRC_ACE_BIT];
	// Enable only; the converter has no external memory port
	assign interlace_to_progressive_o = deint_ff[VRC_DEINT_BIT];

endmodule : vrc_route_config

//--- sim/vrc_host_model.sv
// Host controller model for the two-wire serial register port.
// Assumes a pull-up on the data line; the bench resolves the wire level.
`timescale 1ns/1ps
module vrc_host_model (
	// Clock
	input  wire logic clk_i,
	// Serial lines
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	// ==================================================================
	// Line phases of four clocks, one clock from a clock fall to the next data change, so the port sees every level
	// ==================================================================
	initial begin
		scl_o     = 1'b1;
		sda_low_o = 1'b0;
	end

	// Wait a number of clock edges
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
	endtask : step

	// Start: data falls while clock is high
	task automatic start();
		sda_low_o <= 1'b0;
		step(4);
		scl_o <= 1'b1;
		step(4);
		sda_low_o <= 1'b1;
		step(4);
		scl_o <= 1'b0;
		step(4);
	endtask : start

	// Stop: data rises while clock is high
	task automatic stop();
		sda_low_o <= 1'b1;
		step(4);
		scl_o <= 1'b1;
		step(4);
		sda_low_o <= 1'b0;
		step(4);
	endtask : stop

	// One bit; data changes only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		sda_low_o <= ~b;
		step(4);
		scl_o <= 1'b1;
		step(4);
		r = sda_i;
		scl_o <= 1'b0;
		step(1);
	endtask : bit_io

	// Byte out, most significant bit first; returns the nack level
	task automatic send(input logic [7:0] b, output logic nack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, nack);
	endtask : send

	// Byte in, then ack (nack = 0) or end of read (nack = 1)
	task automatic recv(output logic [7:0] d, input logic nack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(nack, r);
	endtask : recv
endmodule : vrc_host_model

//--- sim/vrc_route_config_sva.sv
// Checker for the routing configuration block, ports only.
// Assumes one clock domain and a bind to every instance of the top.
`timescale 1ns/1ps
module vrc_route_config_sva
	import vrc_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	// Serial and straps
	input  wire logic              scl_i,
	input  wire logic              sda_oe_o,
	input  wire logic              eight_ch_variant_i,
	// Configuration outputs
	input  vrc_pkg::vrc_route_t    route_o,
	input  wire logic [1:0]        register_page_select_o,
	input  wire logic              adaptive_contrast_boost_o,
	input  wire logic              interlace_to_progressive_o
);
	// ==================================================================
	// Route decode relations
	// ==================================================================
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	a_reserved_all_off: assert property (!route_o.valid |->
		route_o.chan_power == 8'h00 && route_o.mode == VRC_MODE_COMPOSITE)
		else $error("reserved route powers a channel");
	a_composite_video_one_chan: assert property (route_o.valid && route_o.mode == VRC_MODE_COMPOSITE
		|-> route_o.chan_power == (8'h01 << route_o.luma_ch)) else $error("composite power");
	a_yc_pair_power: assert property (route_o.valid && route_o.mode == VRC_MODE_LUMA_CHROMA
		|-> route_o.chan_power == (8'h03 << route_o.luma_ch) && !route_o.luma_ch[0])
		else $error("luma chroma power");
	a_comp_three_chan: assert property (route_o.valid && route_o.mode == VRC_MODE_COMPONENT
		|-> route_o.chan_power == (8'h07 << route_o.luma_ch)) else $error("component power");
	a_four_in_limit: assert property (!(eight_ch_variant_i | $past(eight_ch_variant_i) |
		$past(eight_ch_variant_i, 2)) |-> route_o.chan_power[7:4] == 4'h0)
		else $error("upper channel on four-input part");

	// ==================================================================
	// Register updates land with the data acknowledge
	// ==================================================================
	a_page_on_ack: assert property ($changed(register_page_select_o) |-> $rose(sda_oe_o))
		else $error("page changed without ack");
	a_boost_on_ack: assert property ($changed(adaptive_contrast_boost_o) |-> $rose(sda_oe_o))
		else $error("boost changed without ack");
	a_deint_on_ack: assert property ($changed(interlace_to_progressive_o) |-> $rose(sda_oe_o))
		else $error("deinterlacer changed without ack");
	a_ack_scl_low: assert property ($rose(sda_oe_o) |-> !scl_i throughout ##[0:2] 1'b1)
		else $error("ack driven while clock high");
endmodule : vrc_route_config_sva

bind vrc_route_config vrc_route_config_sva u_sva (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
	.eight_ch_variant_i(eight_ch_variant_i), .route_o(route_o),
	.register_page_select_o(register_page_select_o),
	.adaptive_contrast_boost_o(adaptive_contrast_boost_o),
	.interlace_to_progressive_o(interlace_to_progressive_o));

//--- sim/tb.sv
// Self-checking bench: register sequences over the serial port.
// Assumes a pull-up on the data line and the host model as master.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
	import vrc_pkg::*;
	// ==================================================================
	// Signals
	// ==================================================================
	logic       clk_i, rst_b_i, scl, sda_low, sda_w, sda_o_w, sda_oe, pin, eight;
	vrc_route_t route;
	logic [1:0] page;
	logic       boost, deint;
	logic [7:0] wa, d;       // Write address byte, read data
	logic [2:0] nk;          // Nack per byte: address, sub, data
	int         n_fail, total_checks, cyc;

	// Open-drain wire with pull-up
	assign sda_w = sda_low ? 1'b0 : (sda_oe ? sda_o_w : 1'b1);

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	vrc_host_model host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));
	vrc_route_config DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_o_w), .sda_oe_o(sda_oe), .slave_address_select_pin_i(pin),
		.eight_ch_variant_i(eight), .route_o(route), .register_page_select_o(page),
		.adaptive_contrast_boost_o(boost), .interlace_to_progressive_o(deint));

	// ==================================================================
	// Access tasks and expectations
	// ==================================================================
	task automatic reg_wr(input logic [7:0] a, s, v, output logic [2:0] n);
		host.start();
		host.send(a, n[2]);
		host.send(s, n[1]);
		host.send(v, n[0]);
		host.stop();
	endtask : reg_wr

	// Set the subaddress, then read one byte from it
	task automatic reg_rd(input logic [7:0] s, output logic [7:0] v);
		logic n;
		host.start();
		host.send(wa, n);
		host.send(s, n);
		host.stop();
		host.start();
		host.send(wa | 8'h01, n);
		host.recv(v, 1'b1);
		host.stop();
	endtask : reg_rd

	// Expected route for a code on either variant
	function automatic vrc_route_t exp_route(input logic [4:0] c, input logic e);
		vrc_route_t r;
		r = '0;
		r.mode = VRC_MODE_COMPOSITE;
		if (c <= (e ? 5'h07 : 5'h03)) begin
			r.valid = 1'b1;
			r.luma_ch = c[2:0];
			r.chan_power = 8'h01 << c[2:0];
		end else if (c >= 5'h08 && c <= (e ? 5'h0b : 5'h09)) begin
			r.valid = 1'b1;
			r.mode = VRC_MODE_LUMA_CHROMA;
			r.luma_ch = {c[1:0], 1'b0};
			r.chroma_ch = r.luma_ch + 3'h1;
			r.chan_power = 8'h03 << r.luma_ch;
		end else if (c == 5'h0c || (c == 5'h0d && e)) begin
			r.valid = 1'b1;
			r.mode = VRC_MODE_COMPONENT;
			r.luma_ch = c[0] ? 3'h3 : 3'h0;
			r.chroma_ch = r.luma_ch + 3'h1;
			r.third_ch = r.luma_ch + 3'h2;
			r.chan_power = 8'h07 << r.luma_ch;
		end
		return r;
	endfunction : exp_route

	task automatic chk_route(input logic [4:0] c, input logic e);
		vrc_route_t x;
		x = exp_route(c, e);
		`CHK({route.chan_power, route.mode, route.valid}, {x.chan_power, x.mode, x.valid})
		if (x.valid) `CHK(route.luma_ch, x.luma_ch)
		if (x.mode != VRC_MODE_COMPOSITE) `CHK(route.chroma_ch, x.chroma_ch)
		if (x.mode == VRC_MODE_COMPONENT) `CHK(route.third_ch, x.third_ch)
	endtask : chk_route

	task automatic wrap_up();
		if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up

	// Hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			wrap_up();
		end
	end

	// ==================================================================
	// Main sequence
	// ==================================================================
	initial begin
		rst_b_i = 1'b0;
		pin = 1'b0;
		eight = 1'b1;
		wa = 8'h40;
		repeat (20) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk_route(5'h00, 1'b1);
		`CHK({page, boost, deint}, 4'h0)
		// Every code on both variants, reserved ones included
		for (int e = 1; e >= 0; e--) begin
			eight <= e[0];
			for (int c = 0; c < 32; c++) begin
				reg_wr(wa, 8'h00, {3'h0, c[4:0]}, nk);
				`CHK(nk, 3'h0)
				chk_route(c[4:0], e[0]);
				if (e == 1) begin
					reg_rd(8'h00, d);
					`CHK(d, {3'h0, c[4:0]})
				end
			end
		end
		// Leave a defined code behind; reserved codes above were a robustness probe
		reg_wr(wa, 8'h00, 8'h0c, nk);
		chk_route(5'h0c, 1'b0);
		// Contrast boost on, deinterlacer on, back to primary page
		reg_wr(wa, 8'h0e, 8'h40, nk);
		`CHK(page, VRC_PAGE_USR2)
		reg_wr(wa, 8'h80, 8'h80, nk);
		`CHK({nk, boost}, 4'h1)
		reg_rd(8'h80, d);
		`CHK(d, 8'h80)
		reg_wr(wa, 8'h81, 8'h01, nk);
		`CHK(deint, 1'b1)
		reg_wr(wa, 8'h0e, 8'h00, nk);
		`CHK(page, VRC_PAGE_MAIN)
		// Boost register is not on the primary page
		reg_wr(wa, 8'h80, 8'h00, nk);
		`CHK({nk, boost}, 4'h7)
		reg_wr(wa, 8'h0e, 8'h40, nk);
		reg_wr(wa, 8'h80, 8'h00, nk);
		`CHK({nk, boost}, 4'h0)
		// Interrupt page holds only the page register
		reg_wr(wa, 8'h0e, 8'h20, nk);
		`CHK(page, VRC_PAGE_INTR)
		reg_wr(wa, 8'h00, 8'h05, nk);
		`CHK(nk, 3'h3)
		reg_wr(wa, 8'h0e, 8'h00, nk);
		// Strap moves the slave address; both pages answer there
		pin <= 1'b1;
		reg_wr(8'h40, 8'h0e, 8'h40, nk);
		`CHK({nk, page}, 5'h1c)
		wa = 8'h42;
		reg_wr(wa, 8'h0e, 8'h40, nk);
		reg_wr(wa, 8'h80, 8'h80, nk);
		`CHK({nk, page, boost}, 6'h05)
		wrap_up();
	end
endmodule : tb
